/* File: logic/csl_pkg.sv */
// Constants, field layout and scaling for the charge safety limit register.
// Assumes a serial-interface register engine that hands over byte writes.
// What this block does
// - Eight-bit read/write safety register at location 06, reset value 0100_0000.
// - Bits 7..4 hold current ceiling code, weights 54.4/27.2/13.6/6.8 mV.
// - Current ceiling is 37.4 mV plus weighted code; default 64.6, top 139.4.
// - Bits 3..0 hold voltage ceiling code, weights 160/80/40/20 mV, default zero.
// - Voltage ceiling is 4.2 V plus weighted code, up to 4.44 V.
// - Register resets on short with supply, low output without supply, or pin low.
// - After safety reset writes land until any other register is written.
// - Regulation voltage and fast charge current never exceed the safety ceilings.
// - Writing another register first locks in the default ceilings.
// - Location 02 bits 7..2 give voltage in 20 mV steps above 3.5 V.
// - Fast charge current is limited to the lower of absolute maximum and ceiling.
package csl_pkg;
	localparam logic [7:0] ADDR_VREG = 8'h02;
	localparam logic [7:0] ADDR_ICHG = 8'h04;
	localparam logic [7:0] ADDR_SAFETY = 8'h06;
	localparam logic [7:0] SAFETY_RESET = 8'h40;
	// Field positions inside the safety register
	localparam int CUR_MSB = 7;
	localparam int CUR_LSB = 4;
	localparam int VOL_MSB = 3;
	localparam int VOL_LSB = 0;
	// Voltage scale in millivolts
	localparam logic [15:0] VREG_BASE_MV = 16'h0DAC;
	localparam logic [15:0] VMAX_BASE_MV = 16'h1068;
	localparam logic [15:0] VSTEP_MV = 16'h0014;
	// Ceiling code on the location-02 scale: (4200 - 3500) / 20
	localparam logic [5:0] VMAX_BASE_CODE = 6'h23;
	// Top of the regulation range: 4440 mV, code (4440 - 3500) / 20
	localparam logic [15:0] VTOP_MV = 16'h1158;
	localparam logic [5:0] VTOP_CODE = 6'h2F;
	// Current scale in tenths of a millivolt of sense voltage
	localparam logic [15:0] IBASE_TMV = 16'h0176;
	localparam logic [15:0] ISTEP_TMV = 16'h0044;
	localparam logic [15:0] IABS_MAX_TMV = 16'h041E;
	// Absolute maximum 105.4 mV sits at code (1054 - 374) / 68
	localparam logic [3:0] IABS_MAX_CODE = 4'hA;
endpackage

/* File: logic/csl_safety_limit.sv */
// Safety limit register, its write lock and the voltage and current clamps.
// Assumes byte writes and reads arrive from the serial register engine in the clk domain,
// and that the other registers live outside and hand over their charge codes.
`timescale 1ns/1ps
`default_nettype none
module csl_safety_limit (
	input wire logic clk, // 200 MHz register clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic reg_wr, // Write strobe, one cycle
	input wire logic [7:0] reg_addr, // Register location
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, valid one cycle after address
	input wire logic output_short, // Output below short threshold
	input wire logic output_low_reset, // Output below digital reset threshold
	input wire logic input_supply, // Input supply above undervoltage level
	input wire logic safety_reset_pin_n, // Safety reset pin, active low
	input wire logic [5:0] vreg_code, // Requested voltage code, location 02 bits 7..2
	input wire logic [3:0] ichg_code, // Requested current code, location 04 bits 6..3
	output logic [5:0] vreg_eff_code, // Voltage code allowed to take effect
	output logic [3:0] ichg_eff_code, // Current code allowed to take effect
	output logic limits_locked // Safety limits locked
);
	typedef struct packed {
		logic [7:0] safety;
		logic lock;
		logic [7:0] rdata;
		logic [5:0] veff;
		logic [3:0] ieff;
	} csl_state_t;

	csl_state_t s_q;
	csl_state_t s_d;
	logic safety_rst;
	logic [15:0] vreq_mv;
	logic [15:0] vmax_mv;
	logic [15:0] ireq_tmv;
	logic [15:0] imax_tmv;
	logic [3:0] cur_field;
	logic [3:0] vol_field;
	logic [15:0] vlim_mv;
	logic [5:0] vlim_code;

	// ==================================================
	// Safety reset sources and scaled values
	assign safety_rst = (output_short & input_supply) | (output_low_reset & ~input_supply)
		| ~safety_reset_pin_n;
	assign cur_field = s_q.safety[csl_pkg::CUR_MSB:csl_pkg::CUR_LSB];
	assign vol_field = s_q.safety[csl_pkg::VOL_MSB:csl_pkg::VOL_LSB];
	assign vreq_mv = csl_pkg::VREG_BASE_MV + 16'(vreg_code) * csl_pkg::VSTEP_MV;
	assign vmax_mv = csl_pkg::VMAX_BASE_MV + 16'(vol_field) * csl_pkg::VSTEP_MV;
	assign ireq_tmv = csl_pkg::IBASE_TMV + 16'(ichg_code) * csl_pkg::ISTEP_TMV;
	assign imax_tmv = csl_pkg::IBASE_TMV + 16'(cur_field) * csl_pkg::ISTEP_TMV;

	// Voltage limit capped at the top of the regulation range
	assign vlim_mv = (vmax_mv > csl_pkg::VTOP_MV) ? csl_pkg::VTOP_MV : vmax_mv;
	assign vlim_code = (vmax_mv > csl_pkg::VTOP_MV) ? csl_pkg::VTOP_CODE
		: csl_pkg::VMAX_BASE_CODE + 6'(vol_field);

	// ==================================================
	// Next state
	always_comb begin
		s_d = s_q;
		// Write path and lock
		if (safety_rst) begin
			s_d.safety = csl_pkg::SAFETY_RESET;
			s_d.lock = 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == csl_pkg::ADDR_SAFETY) begin
				if (!s_q.lock) begin
					s_d.safety = reg_wdata;
				end
			end else begin
				s_d.lock = 1'b1;
			end
		end
		// Read path
		if (reg_addr == csl_pkg::ADDR_SAFETY) begin
			s_d.rdata = s_q.safety;
		end else begin
			s_d.rdata = 8'h00;
		end
		// Voltage clamp on millivolt scale
		if (vreq_mv > vlim_mv) begin
			s_d.veff = vlim_code;
		end else begin
			s_d.veff = vreg_code;
		end
		// Current clamp to the lower of ceiling and absolute maximum
		if (ireq_tmv > imax_tmv && imax_tmv <= csl_pkg::IABS_MAX_TMV) begin
			s_d.ieff = cur_field;
		end else if (ireq_tmv > csl_pkg::IABS_MAX_TMV) begin
			s_d.ieff = csl_pkg::IABS_MAX_CODE;
		end else begin
			s_d.ieff = ichg_code;
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{safety: csl_pkg::SAFETY_RESET, lock: 1'b0, rdata: 8'h00,
				veff: 6'h00, ieff: 4'h0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign reg_rdata = s_q.rdata;
	assign vreg_eff_code = s_q.veff;
	assign ichg_eff_code = s_q.ieff;
	assign limits_locked = s_q.lock;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ==================================================
	// Write, lock and reset checks
	// Accepted write lands in the register
	a_write_lands: assert property (reg_wr && reg_addr == csl_pkg::ADDR_SAFETY && !s_q.lock
		&& !safety_rst |=> s_q.safety == $past(reg_wdata)) else $error("safety write lost");

	// Locked register holds its value
	a_locked_hold: assert property (s_q.lock && !safety_rst |=>
		$stable(s_q.safety)) else $error("locked register changed");

	// Write to a locked register is dropped
	a_locked_drop: assert property (reg_wr && reg_addr == csl_pkg::ADDR_SAFETY
		&& limits_locked && !safety_rst |=> s_q.safety == $past(s_q.safety))
		else $error("locked write landed");

	// Any other location sets the lock
	a_other_locks: assert property (reg_wr && reg_addr != csl_pkg::ADDR_SAFETY
		&& !safety_rst |=> limits_locked) else $error("lock not set");

	// Lock is only set by a write elsewhere
	a_lock_by_write: assert property (!limits_locked
		&& !(reg_wr && reg_addr != csl_pkg::ADDR_SAFETY) |=> !limits_locked)
		else $error("lock set unprompted");

	// Safety reset restores defaults and opens the register
	a_safety_rst: assert property (safety_rst |=> s_q.safety == csl_pkg::SAFETY_RESET
		&& !limits_locked) else $error("safety reset failed");

	// Lock stays until a safety reset
	a_lock_sticky: assert property (limits_locked && !safety_rst |=> limits_locked)
		else $error("lock dropped");

	// Without write or reset the register keeps its value
	a_quiet_keep: assert property (!reg_wr && !safety_rst |=> $stable(s_q.safety))
		else $error("register changed unprompted");

	// Default ceilings after a safety reset
	a_default_cur: assert property (safety_rst ##1 !safety_rst && !reg_wr |=>
		cur_field == 4'h4 && vol_field == 4'h0) else $error("bad default ceilings");

	// ==================================================
	// Read checks
	// Read returns the register a cycle after the address
	a_read_back: assert property (reg_addr == csl_pkg::ADDR_SAFETY |=>
		reg_rdata == $past(s_q.safety)) else $error("bad readback");

	// Other locations read as zero from this block
	a_read_other: assert property (reg_addr != csl_pkg::ADDR_SAFETY |=>
		reg_rdata == 8'h00) else $error("stray readback");

	// ==================================================
	// Voltage clamp checks
	// Effective voltage never above the ceiling
	a_vreg_cap: assert property (##1 (csl_pkg::VREG_BASE_MV +
		16'(vreg_eff_code) * csl_pkg::VSTEP_MV) <= $past(vmax_mv))
		else $error("voltage above ceiling");

	// Effective voltage never above the top of the range
	a_vreg_top: assert property ((csl_pkg::VREG_BASE_MV
		+ 16'(vreg_eff_code) * csl_pkg::VSTEP_MV) <= csl_pkg::VTOP_MV)
		else $error("voltage above range top");

	// Request above a ceiling inside the range takes the ceiling code
	a_vreg_clamp: assert property (vreq_mv > vmax_mv && vmax_mv <= csl_pkg::VTOP_MV
		|=> vreg_eff_code == $past(csl_pkg::VMAX_BASE_CODE + 6'(vol_field)))
		else $error("voltage not clamped to ceiling");

	// Request above the range top with a wider ceiling takes the top code
	a_vreg_top_pick: assert property (vreq_mv > csl_pkg::VTOP_MV
		&& vmax_mv > csl_pkg::VTOP_MV |=> vreg_eff_code == csl_pkg::VTOP_CODE)
		else $error("voltage not clamped to top");

	// Request inside the limits passes unchanged
	a_vreg_pass: assert property (vreq_mv <= vlim_mv
		|=> vreg_eff_code == $past(vreg_code)) else $error("voltage request altered");

	// ==================================================
	// Current clamp checks
	// Effective current within the ceiling or unchanged
	a_ichg_cap: assert property (##1 ichg_eff_code <= $past(cur_field)
		|| ichg_eff_code == $past(ichg_code)) else $error("current above ceiling");

	// Effective current never above the absolute maximum
	a_ichg_abs: assert property ((csl_pkg::IBASE_TMV
		+ 16'(ichg_eff_code) * csl_pkg::ISTEP_TMV) <= csl_pkg::IABS_MAX_TMV)
		else $error("current above absolute maximum");

	// Request above a ceiling under the maximum takes the ceiling code
	a_ichg_ceiling: assert property (ireq_tmv > imax_tmv
		&& imax_tmv <= csl_pkg::IABS_MAX_TMV |=> ichg_eff_code == $past(cur_field))
		else $error("current not clamped to ceiling");

	// Request above the maximum with a wider ceiling takes the maximum code
	a_ichg_abs_pick: assert property (ireq_tmv > csl_pkg::IABS_MAX_TMV
		&& imax_tmv > csl_pkg::IABS_MAX_TMV |=> ichg_eff_code == csl_pkg::IABS_MAX_CODE)
		else $error("current not clamped to maximum");

	// Request inside both limits passes unchanged
	a_ichg_pass: assert property (ireq_tmv <= imax_tmv
		&& ireq_tmv <= csl_pkg::IABS_MAX_TMV |=> ichg_eff_code == $past(ichg_code))
		else $error("current request altered");

	// ==================================================
	// Coverage of the main scenarios
	// Custom limits written just before another register
	c_custom: cover property (reg_wr && reg_addr == csl_pkg::ADDR_SAFETY ##1
		reg_wr && reg_addr == csl_pkg::ADDR_VREG);
	// Default limits locked by a first write elsewhere
	c_default_lock: cover property (!limits_locked && reg_wr && reg_addr == csl_pkg::ADDR_ICHG);
	// Voltage request above the ceiling
	c_vclamp: cover property (vreq_mv > vmax_mv);
	// Safety reset pin while locked
	c_pin_reset: cover property (limits_locked ##1 !safety_reset_pin_n);
	// Current request and ceiling both above the absolute maximum
	c_abs_cap: cover property (ireq_tmv > csl_pkg::IABS_MAX_TMV && imax_tmv > csl_pkg::IABS_MAX_TMV);
endmodule
`default_nettype wire

/* File: verification/csl_host_model.sv */
// Host side model: single byte writes and read address selects.
// Assumes one bench process calls its tasks, away from clock edges.
`timescale 1ns/1ps
`default_nettype none
module csl_host_model (
	input wire logic clk, // Register clock
	output logic reg_wr, // Write strobe
	output logic [7:0] reg_addr, // Register location
	output logic [7:0] reg_wdata // Write byte
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One-cycle strobe per byte; idle byte shows the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// Address select for a read
	task automatic sel(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Bench for the safety limit register: defaults, lock, clamps, safety resets.
// Assumes the host model drives the register port and this bench the rest.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, nrst, o_short, o_low, sup, pin_n, wr, locked;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] vreg, veff;
	logic [3:0] ichg, ieff;
	int error_cnt = 0, tests_run = 0, cycles = 0;
	logic [3:0] cond [5] = '{4'b1011, 4'b0101, 4'b0010, 4'b1001, 4'b0111};
	csl_host_model i_csl_host_model (.clk(clk), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata));
	csl_safety_limit i_csl_safety_limit (.clk(clk), .nrst(nrst), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .output_short(o_short), .output_low_reset(o_low),
		.input_supply(sup), .safety_reset_pin_n(pin_n), .vreg_code(vreg), .ichg_code(ichg),
		.vreg_eff_code(veff), .ichg_eff_code(ieff), .limits_locked(locked));
	// Clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] e);
		i_csl_host_model.sel(8'h06);
		@(posedge clk);
		#1 chk("rdata", e, rdata);
	endtask
	task automatic clamp(input logic [5:0] v, input logic [3:0] i, input logic [5:0] ve,
		input logic [3:0] ie);
		@(posedge clk);
		vreg <= v;
		ichg <= i;
		@(posedge clk);
		#1 chk("vreg_eff", {2'b00, ve}, {2'b00, veff});
		chk("ichg_eff", {4'h0, ie}, {4'h0, ieff});
	endtask
	task automatic t_custom();
		rd(8'h40);
		chk("locked", 8'h00, {7'h00, locked});
		i_csl_host_model.wr(8'h06, 8'hF4);
		rd(8'hF4);
		i_csl_host_model.wr(8'h02, 8'h00);
		#1 chk("locked", 8'h01, {7'h00, locked});
		i_csl_host_model.wr(8'h06, 8'h00);
		rd(8'hF4);
		clamp(6'h3F, 4'hF, 6'h27, 4'hA);
		clamp(6'h27, 4'h9, 6'h27, 4'h9);
	endtask
	// Reset conditions: short, supply, low output, pin
	task automatic t_resets();
		foreach (cond[k]) begin
			i_csl_host_model.wr(8'h06, 8'hF4);
			i_csl_host_model.wr(8'h02, 8'h00);
			@(posedge clk);
			{o_short, o_low, sup, pin_n} <= cond[k];
			@(posedge clk);
			{o_short, o_low, sup, pin_n} <= 4'b0011;
			@(posedge clk);
			#1 chk("locked", {7'h00, k > 2}, {7'h00, locked});
			rd(k > 2 ? 8'hF4 : 8'h40);
		end
	endtask
	task automatic t_default();
		@(posedge clk);
		pin_n <= 1'b0;
		@(posedge clk);
		pin_n <= 1'b1;
		i_csl_host_model.wr(8'h04, 8'h00);
		i_csl_host_model.wr(8'h06, 8'hFF);
		rd(8'h40);
		clamp(6'h24, 4'hF, 6'h23, 4'h4);
		clamp(6'h23, 4'h3, 6'h23, 4'h3);
	endtask
	// Widest limits: voltage held at the range top, current at the absolute maximum
	task automatic t_top();
		@(posedge clk);
		pin_n <= 1'b0;
		@(posedge clk);
		pin_n <= 1'b1;
		i_csl_host_model.wr(8'h06, 8'hFF);
		i_csl_host_model.wr(8'h05, 8'h00);
		#1 chk("locked", 8'h01, {7'h00, locked});
		clamp(6'h3F, 4'hF, 6'h2F, 4'hA);
		clamp(6'h2E, 4'hA, 6'h2E, 4'hA);
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{nrst, o_short, o_low, sup, pin_n} = 5'b00011;
		vreg = 6'h00;
		ichg = 4'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_custom();
		t_resets();
		t_default();
		t_top();
		give_verdict();
	end
endmodule
`default_nettype wire
